//--- verilog/idc_defines.svh
// register offsets, field positions, reset values and timing counts of the dio conditioning block
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH

// ----------------------------------------
// port geometry
// ----------------------------------------
`define IDC_LINES 96
`define IDC_WORDS 3

// ----------------------------------------
// register byte offsets (line groups take three words each)
// ----------------------------------------
`define IDC_OFS_FILT_EN 8'h00
`define IDC_OFS_RISE_EN 8'h0c
`define IDC_OFS_FALL_EN 8'h18
`define IDC_OFS_DIR 8'h24
`define IDC_OFS_OUT 8'h30
`define IDC_OFS_SAFE 8'h3c
`define IDC_OFS_IN 8'h48
`define IDC_OFS_FILT_PER 8'h54
`define IDC_OFS_WD_TMO 8'h58
`define IDC_OFS_WD_CTRL 8'h5c
`define IDC_OFS_STATUS 8'h60

// ----------------------------------------
// field positions
// ----------------------------------------
`define IDC_WDC_ENABLE 0
`define IDC_WDC_REFRESH 1
`define IDC_ST_EVENT 0
`define IDC_ST_OVERFLOW 1
`define IDC_ST_EXPIRED 2
`define IDC_ST_OVERCURRENT 3
`define IDC_ST_SAFE_HOLD 4

// ----------------------------------------
// timing
// ----------------------------------------
`define IDC_SYS_MHZ 100
`define IDC_SAMPLE_MHZ 48
`define IDC_FILT_INT_NS 200
// half interval in sample ticks, rounded up
`define IDC_FILT_PER_RST ((`IDC_FILT_INT_NS * `IDC_SAMPLE_MHZ + 1999) / 2000)
`define IDC_WD_TMO_RST 32'hffffffff
`define IDC_BLINK_MS 250
`define IDC_BLINK_CYC (`IDC_BLINK_MS * `IDC_SYS_MHZ * 1000)

`endif

//--- verilog/idc_pkg.sv
// types shared by the dio conditioning block
`default_nettype none
package idc_pkg;
	typedef logic [95:0] idc_line_type;
	typedef logic [31:0] idc_word_type;
	typedef enum logic [1:0] {BOOT_HOLD, BOOT_LOAD, BOOT_RUN} idc_boot_type;
endpackage
`default_nettype wire

//--- verilog/idc_filter.sv
// shared-interval glitch filter for all lines
`default_nettype none
`include "idc_defines.svh"
module idc_filter (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// sample tick and setup
	input wire logic tick,
	input wire idc_pkg::idc_word_type per,
	input wire idc_pkg::idc_line_type en,
	// lines
	input wire idc_pkg::idc_line_type smp,
	output var idc_pkg::idc_line_type val
);
	import idc_pkg::*;

	idc_word_type div_reg;
	idc_line_type cand_reg;
	idc_line_type flt_reg;
	logic ftick;

	// ----------------------------------------
	// filter clock divider
	// ----------------------------------------
	// half-interval divider
	assign ftick = tick && ((div_reg + 32'h1) >= per);

	// a shrunk period fires at once instead of wrapping the counter
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			div_reg <= '0;
		end else if (tick) begin
			div_reg <= ftick ? '0 : div_reg + 32'h1;
		end
	end

	// ----------------------------------------
	// two-edge agreement
	// ----------------------------------------
	// two stable filter edges
	// the same test serves both directions, so rise and fall are treated alike
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cand_reg <= '0;
			flt_reg <= '0;
		end else if (ftick) begin
			cand_reg <= smp;
			flt_reg <= (flt_reg & (smp ^ cand_reg)) | (smp & ~(smp ^ cand_reg));
		end
	end

	always_comb begin
		val = (en & flt_reg) | (~en & smp);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_filt_hold;
		@(posedge sys_clk) disable iff (srst)
		!ftick |=> (flt_reg == $past(flt_reg));
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("filtered value moved without a filter edge");

	property p_ftick_gap;
		@(posedge sys_clk) disable iff (srst)
		ftick |=> !ftick;
	endproperty
	a_ftick_gap: assert property (p_ftick_gap) else $error("filter edges on adjacent cycles");
endmodule
`default_nettype wire

//--- verilog/idc_wdog.sv
// output watchdog timer counting sample ticks
`default_nettype none
`include "idc_defines.svh"
module idc_wdog (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// control
	input wire logic tick,
	input wire logic arm,
	input wire logic refresh,
	input wire idc_pkg::idc_word_type timeout,
	// state
	output var logic expired
);
	import idc_pkg::*;

	idc_word_type cnt_reg;
	logic exp_reg;

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	// 32-bit tick countdown
	// disarm is the only way out of expiry short of a reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cnt_reg <= `IDC_WD_TMO_RST;
			exp_reg <= 1'b0;
		end else if (!arm) begin
			cnt_reg <= timeout;
			exp_reg <= 1'b0;
		end else if (exp_reg) begin
			exp_reg <= 1'b1;
		end else if (refresh) begin
			cnt_reg <= timeout;
		end else if (tick) begin
			if (cnt_reg == '0) begin
				exp_reg <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg - 32'h1;
			end
		end
	end

	assign expired = exp_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_exp_hold;
		@(posedge sys_clk) disable iff (srst)
		exp_reg && arm |=> exp_reg;
	endproperty
	a_exp_hold: assert property (p_exp_hold) else $error("expiry dropped while armed");

	property p_reload;
		@(posedge sys_clk) disable iff (srst)
		arm && refresh && !exp_reg |=> (cnt_reg == $past(timeout)) && !exp_reg;
	endproperty
	a_reload: assert property (p_reload) else $error("refresh did not restart the count");

	property p_disarm;
		@(posedge sys_clk) disable iff (srst)
		!arm |=> !exp_reg;
	endproperty
	a_disarm: assert property (p_disarm) else $error("expiry survived disarm");
endmodule
`default_nettype wire

//--- verilog/idc_top.sv
// dio conditioning block: filter, change detect, power-up states, watchdog, apb registers
// Function
// - filter drops pulses under half interval, passes pulses over full interval
// - filter chosen per line; one shared interval, 200 ns to 200 ms
// - every input sampled at least at the 48 MHz sample rate
// - a counter makes a filter clock of half the interval
// - filtered value changes only after two stable filter clock edges
// - rise and fall filtered alike; passing takes up to one interval
// - drivers off at power-up, then each line takes its stored state
// - a programmed drive state overrides the weak pull level
// - separate rise and fall detect enables per line
// - any enabled edge outside overcurrent raises one event naming no line or direction
// - overflow set on a new edge while the event is unserviced
// - change-detect lines read a snapshot taken at every detected edge
// - watchdog timeout forces safe values until disarm plus write or reset
// - expiry stays asserted until the watchdog is disarmed
// - output value writes are dropped while expired
// - undriven lines stay undriven on expiry
// - timeout is a 32-bit count of sample ticks
// - every line is an input right after power-on
// - overcurrent disables all lines and blinks the status light
`default_nettype none
`include "idc_defines.svh"
module idc_top #(
	parameter idc_pkg::idc_line_type PWRUP_DIR = '0,
	parameter idc_pkg::idc_line_type PWRUP_VAL = '0,
	parameter int BLINK_CYC = `IDC_BLINK_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	// digital lines
	input wire idc_pkg::idc_line_type dio_in,
	output var idc_pkg::idc_line_type dio_out,
	output var idc_pkg::idc_line_type dio_oe,
	// supply monitor and indicators
	input wire logic ovc_in,
	output var logic chg_event,
	output var logic wd_expired,
	output var logic led_on
);
	import idc_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int w);
		return a == (base + 8'(4 * w));
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	idc_line_type din_s1_reg, din_s2_reg;
	logic ovc_s1_reg, ovc_s2_reg;
	logic [6:0] acc_reg;
	logic tick;
	idc_boot_type boot_reg;
	logic setup, acc_wr;
	logic [31:0] fen_reg [`IDC_WORDS];
	logic [31:0] ren_reg [`IDC_WORDS];
	logic [31:0] fall_reg [`IDC_WORDS];
	logic [31:0] dir_reg [`IDC_WORDS];
	logic [31:0] out_reg [`IDC_WORDS];
	logic [31:0] safe_reg [`IDC_WORDS];
	idc_line_type fen_v, ren_v, fall_v, dir_v, out_v, safe_v, in_v;
	idc_word_type filt_per_reg, wd_tmo_reg;
	logic wd_en_reg, wd_refresh, wd_exp;
	idc_line_type cur, prev_reg, snap_reg, edges, cd_mask;
	logic det, evt_reg, ovf_reg, evt_clr, ovf_clr;
	logic out_wr, hold_reg, force_safe;
	logic [31:0] blink_reg;
	logic blink_ph_reg;
	logic [31:0] rd_next;
	logic err_next;

	// ----------------------------------------
	// input synchronisers and sample tick
	// ----------------------------------------
	// two-flop sampling every clock
	// the 100 MHz sampling is finer than the 48 MHz sample clock, never coarser
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			din_s1_reg <= '0;
			din_s2_reg <= '0;
			ovc_s1_reg <= 1'b0;
			ovc_s2_reg <= 1'b0;
		end else begin
			din_s1_reg <= dio_in;
			din_s2_reg <= din_s1_reg;
			ovc_s1_reg <= ovc_in;
			ovc_s2_reg <= ovc_s1_reg;
		end
	end

	// fractional accumulator gives 48 ticks per 100 clocks, no clock domain needed
	// compare one bit wider: acc plus step reaches 144 and would wrap in seven bits
	assign tick = (8'(acc_reg) + 8'(`IDC_SAMPLE_MHZ)) >= 8'(`IDC_SYS_MHZ);
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			acc_reg <= '0;
		end else if (tick) begin
			acc_reg <= acc_reg + 7'(`IDC_SAMPLE_MHZ) - 7'(`IDC_SYS_MHZ);
		end else begin
			acc_reg <= acc_reg + 7'(`IDC_SAMPLE_MHZ);
		end
	end

	// ----------------------------------------
	// boot sequence
	// ----------------------------------------
	// inputs first, then power-up states
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boot_reg <= BOOT_HOLD;
		end else begin
			unique case (boot_reg)
				BOOT_HOLD: boot_reg <= BOOT_LOAD;
				BOOT_LOAD: boot_reg <= BOOT_RUN;
				BOOT_RUN: boot_reg <= BOOT_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// apb handshake
	// ----------------------------------------
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pready && pwrite;

	// one wait-free access phase: the answer is registered during setup
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup && err_next;
			if (setup) begin
				prdata <= pwrite ? '0 : rd_next;
			end
		end
	end

	// ----------------------------------------
	// line group registers
	// ----------------------------------------
	for (genvar w = 0; w < `IDC_WORDS; w++) begin : g_word
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				fen_reg[w] <= '0;
				ren_reg[w] <= '0;
				fall_reg[w] <= '0;
				safe_reg[w] <= '0;
			end else if (acc_wr) begin
				if (hit(paddr, `IDC_OFS_FILT_EN, w)) fen_reg[w] <= merge(fen_reg[w], pwdata, pstrb);
				if (hit(paddr, `IDC_OFS_RISE_EN, w)) ren_reg[w] <= merge(ren_reg[w], pwdata, pstrb);
				if (hit(paddr, `IDC_OFS_FALL_EN, w)) fall_reg[w] <= merge(fall_reg[w], pwdata, pstrb);
				if (hit(paddr, `IDC_OFS_SAFE, w)) safe_reg[w] <= merge(safe_reg[w], pwdata, pstrb);
			end
		end

		// stored states, output value writes dropped on expiry
		always_ff @(posedge sys_clk) begin
			if (srst) begin
				dir_reg[w] <= '0;
				out_reg[w] <= '0;
			end else if (boot_reg == BOOT_LOAD) begin
				dir_reg[w] <= PWRUP_DIR[32 * w +: 32];
				out_reg[w] <= PWRUP_VAL[32 * w +: 32];
			end else if (acc_wr) begin
				if (hit(paddr, `IDC_OFS_DIR, w)) dir_reg[w] <= merge(dir_reg[w], pwdata, pstrb);
				if (hit(paddr, `IDC_OFS_OUT, w) && !wd_exp) out_reg[w] <= merge(out_reg[w], pwdata, pstrb);
			end
		end

		assign fen_v[32 * w +: 32] = fen_reg[w];
		assign ren_v[32 * w +: 32] = ren_reg[w];
		assign fall_v[32 * w +: 32] = fall_reg[w];
		assign dir_v[32 * w +: 32] = dir_reg[w];
		assign out_v[32 * w +: 32] = out_reg[w];
		assign safe_v[32 * w +: 32] = safe_reg[w];
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	assign wd_refresh = acc_wr && hit(paddr, `IDC_OFS_WD_CTRL, 0) && pstrb[0] && pwdata[`IDC_WDC_REFRESH];
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			filt_per_reg <= 32'(`IDC_FILT_PER_RST);
			wd_tmo_reg <= `IDC_WD_TMO_RST;
			wd_en_reg <= 1'b0;
		end else if (acc_wr) begin
			if (hit(paddr, `IDC_OFS_FILT_PER, 0)) filt_per_reg <= merge(filt_per_reg, pwdata, pstrb);
			if (hit(paddr, `IDC_OFS_WD_TMO, 0)) wd_tmo_reg <= merge(wd_tmo_reg, pwdata, pstrb);
			if (hit(paddr, `IDC_OFS_WD_CTRL, 0) && pstrb[0]) wd_en_reg <= pwdata[`IDC_WDC_ENABLE];
		end
	end

	// ----------------------------------------
	// filter and watchdog
	// ----------------------------------------
	idc_filter u_filter (
		.sys_clk(sys_clk),
		.srst(srst),
		.tick(tick),
		.per(filt_per_reg),
		.en(fen_v),
		.smp(din_s2_reg),
		.val(cur)
	);

	idc_wdog u_wdog (
		.sys_clk(sys_clk),
		.srst(srst),
		.tick(tick),
		.arm(wd_en_reg),
		.refresh(wd_refresh),
		.timeout(wd_tmo_reg),
		.expired(wd_exp)
	);

	// ----------------------------------------
	// change detection
	// ----------------------------------------
	// edges of the filtered value
	assign edges = (~prev_reg & cur & ren_v) | (prev_reg & ~cur & fall_v);
	assign det = (boot_reg == BOOT_RUN) && !ovc_s2_reg && (|edges);
	assign evt_clr = acc_wr && hit(paddr, `IDC_OFS_STATUS, 0) && pstrb[0] && pwdata[`IDC_ST_EVENT];
	assign ovf_clr = acc_wr && hit(paddr, `IDC_OFS_STATUS, 0) && pstrb[0] && pwdata[`IDC_ST_OVERFLOW];
	assign cd_mask = ren_v | fall_v;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= cur;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			evt_reg <= 1'b0;
		end else if (det) begin
			evt_reg <= 1'b1;
		end else if (evt_clr) begin
			evt_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ovf_reg <= 1'b0;
		end else if (det && evt_reg && !evt_clr) begin
			ovf_reg <= 1'b1;
		end else if (ovf_clr) begin
			ovf_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			snap_reg <= '0;
		end else if (det) begin
			snap_reg <= cur;
		end
	end

	// inputs read as zero while the supply is in overcurrent
	assign in_v = ovc_s2_reg ? '0 : ((cd_mask & snap_reg) | (~cd_mask & cur));

	// ----------------------------------------
	// safe state and pin drive
	// ----------------------------------------
	assign out_wr = acc_wr && !wd_exp && (paddr >= `IDC_OFS_OUT) && (paddr < `IDC_OFS_SAFE);

	// safe values held past disarm until a fresh output write
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			hold_reg <= 1'b0;
		end else if (wd_exp) begin
			hold_reg <= 1'b1;
		end else if (out_wr) begin
			hold_reg <= 1'b0;
		end
	end
	assign force_safe = wd_exp || hold_reg;

	// drive follows direction, off until boot ends and during overcurrent
	// driven lines beat the weak pull; expiry swaps values, never enables
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dio_oe <= '0;
			dio_out <= '0;
		end else begin
			dio_oe <= ((boot_reg == BOOT_RUN) && !ovc_s2_reg) ? dir_v : '0;
			dio_out <= force_safe ? safe_v : out_v;
		end
	end

	// ----------------------------------------
	// status outputs and indicator
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			chg_event <= 1'b0;
			wd_expired <= 1'b0;
		end else begin
			chg_event <= evt_reg;
			wd_expired <= wd_exp;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			blink_reg <= '0;
			blink_ph_reg <= 1'b0;
			led_on <= 1'b0;
		end else begin
			if (blink_reg >= 32'(BLINK_CYC - 1)) begin
				blink_reg <= '0;
				blink_ph_reg <= !blink_ph_reg;
			end else begin
				blink_reg <= blink_reg + 32'h1;
			end
			led_on <= ovc_s2_reg ? blink_ph_reg : 1'b1;
		end
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// read-only words refuse writes with an error
	always_comb begin
		rd_next = '0;
		err_next = 1'b1;
		for (int w = 0; w < `IDC_WORDS; w++) begin
			if (hit(paddr, `IDC_OFS_FILT_EN, w)) begin rd_next = fen_reg[w]; err_next = 1'b0; end
			if (hit(paddr, `IDC_OFS_RISE_EN, w)) begin rd_next = ren_reg[w]; err_next = 1'b0; end
			if (hit(paddr, `IDC_OFS_FALL_EN, w)) begin rd_next = fall_reg[w]; err_next = 1'b0; end
			if (hit(paddr, `IDC_OFS_DIR, w)) begin rd_next = dir_reg[w]; err_next = 1'b0; end
			if (hit(paddr, `IDC_OFS_OUT, w)) begin rd_next = out_reg[w]; err_next = 1'b0; end
			if (hit(paddr, `IDC_OFS_SAFE, w)) begin rd_next = safe_reg[w]; err_next = 1'b0; end
			if (hit(paddr, `IDC_OFS_IN, w)) begin rd_next = in_v[32 * w +: 32]; err_next = pwrite; end
		end
		if (hit(paddr, `IDC_OFS_FILT_PER, 0)) begin rd_next = filt_per_reg; err_next = 1'b0; end
		if (hit(paddr, `IDC_OFS_WD_TMO, 0)) begin rd_next = wd_tmo_reg; err_next = 1'b0; end
		if (hit(paddr, `IDC_OFS_WD_CTRL, 0)) begin rd_next = {31'h0, wd_en_reg}; err_next = 1'b0; end
		if (hit(paddr, `IDC_OFS_STATUS, 0)) begin
			rd_next = {27'h0, hold_reg, ovc_s2_reg, wd_exp, ovf_reg, evt_reg};
			err_next = 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	property p_boot_off;
		$fell(srst) |-> (dio_oe == '0) ##1 (dio_oe == '0);
	endproperty
	a_boot_off: assert property (p_boot_off) else $error("drivers on right after reset");

	property p_evt_set;
		det |=> evt_reg ##1 chg_event;
	endproperty
	a_evt_set: assert property (p_evt_set) else $error("edge did not raise the event");

	property p_ovf_set;
		det && evt_reg && !evt_clr |=> ovf_reg;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");

	property p_snap_hold;
		!det |=> snap_reg == $past(snap_reg);
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved without an event");

	property p_force_safe;
		wd_exp |=> dio_out == $past(safe_v);
	endproperty
	a_force_safe: assert property (p_force_safe) else $error("safe values not driven on expiry");

	property p_wr_drop;
		wd_exp && acc_wr |=> out_v == $past(out_v);
	endproperty
	a_wr_drop: assert property (p_wr_drop) else $error("output write taken while expired");

	property p_tristate;
		wd_exp && (boot_reg == BOOT_RUN) && !ovc_s2_reg |=> dio_oe == $past(dir_v);
	endproperty
	a_tristate: assert property (p_tristate) else $error("expiry changed the enables");

	property p_ovc_off;
		ovc_s2_reg |=> dio_oe == '0;
	endproperty
	a_ovc_off: assert property (p_ovc_off) else $error("lines driven during overcurrent");

	property p_pready;
		setup |=> pready ##1 !pready;
	endproperty
	a_pready: assert property (p_pready) else $error("access phase not one cycle");
endmodule
`default_nettype wire

//--- dv/idc_field_model.sv
// field-side model of the lines: external levels, overridden where the block drives
`default_nettype none
module idc_field_model (
	// levels set by the outside world
	input wire idc_pkg::idc_line_type lvl,
	// block side
	input wire idc_pkg::idc_line_type dio_out,
	input wire idc_pkg::idc_line_type dio_oe,
	output var idc_pkg::idc_line_type dio_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// driven beats pull
	// a driven line wins over the weak external level, so the block reads back its own value
	assign dio_in = (dio_oe & dio_out) | (~dio_oe & lvl);
endmodule
`default_nettype wire

//--- dv/industrial_dio_conditioning_tb.sv
// self-checking bench for the dio conditioning block
`default_nettype none
`include "idc_defines.svh"
module industrial_dio_conditioning_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import idc_pkg::*;
	logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err, ovc = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, chg_event, wd_expired, led_on;
	idc_line_type lvl = '0, dio_in, dio_out, dio_oe;
	int failures = 0, n_checks = 0, cyc = 0;

	// ----------------------------------------
	// clock, design and field model
	// ----------------------------------------
	always #5 sys_clk = ~sys_clk;
	// blink count shortened so the light logic moves in a short run
	idc_top #(.BLINK_CYC(8)) uut (.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe),
		.ovc_in(ovc), .chg_event(chg_event), .wd_expired(wd_expired), .led_on(led_on));
	idc_field_model fld (.lvl(lvl), .dio_out(dio_out), .dio_oe(dio_oe), .dio_in(dio_in));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task finish_test;
		if (failures == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// hang guard, far above the roughly six hundred cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s exp %h saw %h", nm, e, s);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// one apb transfer; holds the request until pready is seen high
	task apb(input logic [7:0] a, input logic wr_n, input logic [31:0] d);
		@(posedge sys_clk);
		paddr <= a;
		pwrite <= wr_n;
		pwdata <= d;
		psel <= 1;
		@(posedge sys_clk);
		penable <= 1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1, d);
	endtask
	task rg(input logic [7:0] a);
		apb(a, 0, '0);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk("oe", dio_oe[31:0], 0);
		rg(`IDC_OFS_WD_TMO);
		chk("tmo", rd, 32'hffffffff);
		rg(`IDC_OFS_FILT_PER);
		chk("per", rd, 32'h5);
		rg(8'hfc);
		chk("unmapped", {31'h0, err}, 1);
	endtask
	task t_event;
		wr(`IDC_OFS_RISE_EN, 32'h1);
		wr(`IDC_OFS_FALL_EN, 32'h2);
		lvl[1] <= 1;
		w(10);
		chk("no rise1", {31'h0, chg_event}, 0);
		lvl[1] <= 0;
		w(10);
		chk("fall1", {31'h0, chg_event}, 1);
		lvl[0] <= 1;
		w(10);
		rg(`IDC_OFS_STATUS);
		chk("ovf", rd[1:0], 2'h3);
		rg(`IDC_OFS_IN);
		chk("snap", rd[0], 1);
		wr(`IDC_OFS_STATUS, 32'h3);
		w(3);
		chk("clr", {31'h0, chg_event}, 0);
	endtask
	task t_filter;
		wr(`IDC_OFS_FILT_EN, 32'h4);
		wr(`IDC_OFS_RISE_EN, 32'h4);
		lvl[2] <= 1;
		w(3);
		lvl[2] <= 0;
		w(40);
		chk("glitch", {31'h0, chg_event}, 0);
		lvl[2] <= 1;
		w(50);
		chk("pass", {31'h0, chg_event}, 1);
		wr(`IDC_OFS_STATUS, 32'h3);
	endtask
	task t_wdog;
		wr(`IDC_OFS_DIR, 32'hff);
		wr(`IDC_OFS_OUT, 32'h0f);
		wr(`IDC_OFS_SAFE, 32'ha5);
		wr(`IDC_OFS_WD_TMO, 32'd60);
		wr(`IDC_OFS_WD_CTRL, 32'h1);
		// refresh well inside the 60-tick timeout
		repeat (3) begin
			w(50);
			wr(`IDC_OFS_WD_CTRL, 32'h3);
		end
		chk("alive", {31'h0, wd_expired}, 0);
		w(200);
		chk("expired", {31'h0, wd_expired}, 1);
		chk("safe", dio_out[7:0], 8'ha5);
		chk("tri", dio_oe[31:0], 32'hff);
		wr(`IDC_OFS_OUT, 32'h0);
		w(20);
		chk("dropped", dio_out[7:0], 8'ha5);
		chk("sticky", {31'h0, wd_expired}, 1);
		wr(`IDC_OFS_WD_CTRL, 32'h0);
		w(3);
		chk("disarm", {31'h0, wd_expired}, 0);
		chk("hold", dio_out[7:0], 8'ha5);
		wr(`IDC_OFS_OUT, 32'h3c);
		w(2);
		chk("new out", dio_out[7:0], 8'h3c);
	endtask
	// overcurrent drops all drives and blinks the light at the shortened rate
	task t_ovc;
		logic a;
		chk("led steady", {31'h0, led_on}, 1);
		ovc <= 1;
		w(4);
		chk("ovc oe", dio_oe[31:0], 0);
		a = led_on;
		w(8);
		chk("blink", {31'h0, led_on != a}, 1);
		rg(`IDC_OFS_STATUS);
		chk("ovc flag", {31'h0, rd[3]}, 1);
		ovc <= 0;
		w(6);
		chk("ovc off", dio_oe[31:0], 32'hff);
	endtask

	initial begin
		w(10);
		srst <= 0;
		w(4);
		t_reset();
		t_event();
		t_filter();
		t_wdog();
		t_ovc();
		finish_test();
	end
endmodule
`default_nettype wire
